// *** rsf_lost_clock_detector.sv ***
// watches the sampled system clock level and flags a clock stuck high or low
`timescale 1ns/100ps
module rsf_lost_clock_detector #(
    parameter int TIMEOUT_CYCLES = rsf_pkg::LCLK_TIMEOUT_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic sysclk_level,
    output logic      timeout
);
    rsf_pkg::rsf_lclk_state_t s_reg;
    rsf_pkg::rsf_lclk_state_t s_next;

    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << rsf_pkg::LCLK_W) - 1) begin : g_timeout_range_bad
        $error("timeout count does not fit the detector counter");
    end

    always_comb begin
        s_next = s_reg;
        s_next.level_prev = sysclk_level;
        if (!enable || sysclk_level != s_reg.level_prev) begin
            s_next.count   = '0;
            s_next.timeout = 1'b0;
        end else if (s_reg.count == TIMEOUT_CYCLES[rsf_pkg::LCLK_W-1:0]) begin
            // level held longer than the timeout
            s_next.timeout = 1'b1;
        end else begin
            s_next.count = s_reg.count + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign timeout = s_reg.timeout;

    timeout_needs_enable_a : assert property (
        @(posedge clk) disable iff (reset) $rose(timeout) |-> $past(enable) && $past(sysclk_level) == sysclk_level)
        else $error("lost clock timeout without enable or with a toggling clock");
    toggle_clears_a : assert property (
        @(posedge clk) disable iff (reset) (sysclk_level != s_reg.level_prev) |=> !timeout)
        else $error("lost clock timeout survived a clock edge");
endmodule

// *** rsf_pkg.sv ***
// constants and carrier types for the reset cause and source enable block
package rsf_pkg;
    localparam logic [7:0] RSF_ADDR           = 8'hEF;
    localparam int         BIT_USB            = 7;
    localparam int         BIT_FLASH          = 6;
    localparam int         BIT_CMP            = 5;
    localparam int         BIT_SW             = 4;
    localparam int         BIT_WDT            = 3;
    localparam int         BIT_LCLK           = 2;
    localparam int         BIT_SUPPLY         = 1;
    localparam int         BIT_PIN            = 0;
    localparam logic [7:0] CAUSE_AFTER_POR    = 8'h02;
    localparam logic [7:0] ENABLE_WRITABLE    = 8'hA6;
    localparam logic [7:0] ENABLE_AFTER_RESET = 8'h02;
    localparam int         HOLD_W             = 8;
    localparam int         HOLD_CYCLES        = 8;
    localparam int         LCLK_W             = 16;
    localparam int         LCLK_TIMEOUT_CYCLES = 64;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } rsf_sfr_req_t;

    typedef struct packed {
        logic [7:0]        enable;
        logic [7:0]        cause;
        logic [HOLD_W-1:0] hold;
        logic              vbus_prev;
        logic              sys_reset;
        logic [7:0]        rdata;
    } rsf_state_t;

    typedef struct packed {
        logic [LCLK_W-1:0] count;
        logic              level_prev;
        logic              timeout;
    } rsf_lclk_state_t;
endpackage

// *** rsf_reset_source_flags.sv ***
// reset cause flags, reset source enables and system reset generation
`timescale 1ns/100ps
module rsf_reset_source_flags #(
    parameter int HOLD_CYCLES         = rsf_pkg::HOLD_CYCLES,
    parameter int LCLK_TIMEOUT_CYCLES = rsf_pkg::LCLK_TIMEOUT_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  reset,
    input  wire rsf_pkg::rsf_sfr_req_t sfr_req,
    input  wire logic                  usb_bus_reset,
    input  wire logic                  vbus_level,
    input  wire logic                  cmp0_out,
    input  wire logic                  wdt_overflow,
    input  wire logic                  flash_fault,
    input  wire logic                  supply_ok,
    input  wire logic                  rst_pin_n,
    input  wire logic                  sysclk_level,
    output logic [7:0]                 sfr_rdata,
    output logic                       sys_reset
);
    rsf_pkg::rsf_state_t s_reg;
    rsf_pkg::rsf_state_t s_next;
    logic [7:0]          ev;
    logic                wr_hit;
    logic                rd_hit;
    logic                lost_timeout;
    logic                hold_extend;

    if (HOLD_CYCLES < 1 || HOLD_CYCLES > (1 << rsf_pkg::HOLD_W) - 1) begin : g_hold_range_bad
        $error("reset hold count does not fit the hold counter");
    end

    // fixed priority when several causes coincide; supply and pin outrank the rest
    function automatic logic [7:0] pick_cause(input logic [7:0] e);
        logic [7:0] r;
        r = 8'h00;
        if (e[rsf_pkg::BIT_SUPPLY]) begin
            r[rsf_pkg::BIT_SUPPLY] = 1'b1;
        end else if (e[rsf_pkg::BIT_PIN]) begin
            r[rsf_pkg::BIT_PIN] = 1'b1;
        end else if (e[rsf_pkg::BIT_LCLK]) begin
            r[rsf_pkg::BIT_LCLK] = 1'b1;
        end else if (e[rsf_pkg::BIT_FLASH]) begin
            r[rsf_pkg::BIT_FLASH] = 1'b1;
        end else if (e[rsf_pkg::BIT_WDT]) begin
            r[rsf_pkg::BIT_WDT] = 1'b1;
        end else if (e[rsf_pkg::BIT_CMP]) begin
            r[rsf_pkg::BIT_CMP] = 1'b1;
        end else if (e[rsf_pkg::BIT_USB]) begin
            r[rsf_pkg::BIT_USB] = 1'b1;
        end else if (e[rsf_pkg::BIT_SW]) begin
            r[rsf_pkg::BIT_SW] = 1'b1;
        end
        return r;
    endfunction

    rsf_lost_clock_detector #(
        .TIMEOUT_CYCLES (LCLK_TIMEOUT_CYCLES)
    ) u_lost_clock (
        .clk          (clk),
        .reset        (reset),
        .enable       (s_reg.enable[rsf_pkg::BIT_LCLK] && !s_reg.sys_reset),
        .sysclk_level (sysclk_level),
        .timeout      (lost_timeout)
    );

    // no page select input: the register decodes the same on every page
    assign wr_hit = sfr_req.wr && sfr_req.addr == rsf_pkg::RSF_ADDR;
    assign rd_hit = sfr_req.rd && sfr_req.addr == rsf_pkg::RSF_ADDR;

    assign ev[rsf_pkg::BIT_USB]    = s_reg.enable[rsf_pkg::BIT_USB]
                                     && (usb_bus_reset || vbus_level != s_reg.vbus_prev);
    assign ev[rsf_pkg::BIT_FLASH]  = flash_fault;
    assign ev[rsf_pkg::BIT_CMP]    = s_reg.enable[rsf_pkg::BIT_CMP] && !cmp0_out;
    assign ev[rsf_pkg::BIT_SW]     = wr_hit && sfr_req.wdata[rsf_pkg::BIT_SW];
    assign ev[rsf_pkg::BIT_WDT]    = wdt_overflow;
    assign ev[rsf_pkg::BIT_LCLK]   = lost_timeout;
    assign ev[rsf_pkg::BIT_SUPPLY] = s_reg.enable[rsf_pkg::BIT_SUPPLY] && !supply_ok;
    assign ev[rsf_pkg::BIT_PIN]    = !rst_pin_n;

    // pin and supply hold the system in reset for as long as they stay asserted
    assign hold_extend = ev[rsf_pkg::BIT_PIN] || ev[rsf_pkg::BIT_SUPPLY];

    always_comb begin
        s_next = s_reg;
        // tracked even in reset, so enabling usb later sees no stale supply edge
        s_next.vbus_prev = vbus_level;
        if (rd_hit) begin
            s_next.rdata = s_reg.cause;
        end
        if (s_reg.sys_reset) begin
            // other causes and writes are ignored while the reset is held
            if (hold_extend) begin
                s_next.hold = HOLD_CYCLES[rsf_pkg::HOLD_W-1:0];
            end else if (s_reg.hold != '0) begin
                s_next.hold = s_reg.hold - 8'h01;
            end
            s_next.sys_reset = s_next.hold != '0;
        end else if (ev != 8'h00) begin
            s_next.cause     = pick_cause(ev);
            s_next.enable    = rsf_pkg::ENABLE_AFTER_RESET;
            s_next.hold      = HOLD_CYCLES[rsf_pkg::HOLD_W-1:0];
            s_next.sys_reset = 1'b1;
        end else if (wr_hit) begin
            // stored enables only; write data reaches the cause flags only through the software force bit
            s_next.enable = sfr_req.wdata & rsf_pkg::ENABLE_WRITABLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_reg.enable    <= rsf_pkg::ENABLE_AFTER_RESET;
            s_reg.cause     <= rsf_pkg::CAUSE_AFTER_POR;
            s_reg.hold      <= HOLD_CYCLES[rsf_pkg::HOLD_W-1:0];
            s_reg.vbus_prev <= 1'b0;
            s_reg.sys_reset <= 1'b1;
            s_reg.rdata     <= 8'h00;
        end else begin
            s_reg <= s_next;
        end
    end

    // the pin is only sampled here; no internal cause has a path back to it
    assign sys_reset = s_reg.sys_reset;
    assign sfr_rdata = s_reg.rdata;

    cause_onehot_a : assert property (
        @(posedge clk) disable iff (reset) $onehot(s_reg.cause))
        else $error("cause flags not exactly one");
    pin_cause_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && !rst_pin_n && !ev[rsf_pkg::BIT_SUPPLY]
            |=> sys_reset && s_reg.cause == 8'h01)
        else $error("pin reset not recorded");
    sw_force_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && ev == 8'h10
            |=> sys_reset && s_reg.cause == 8'h10 ##1 sys_reset)
        else $error("software force did not reset");
    usb_source_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && s_reg.enable[7] && vbus_level != s_reg.vbus_prev
            |=> sys_reset)
        else $error("bus supply change with usb enabled gave no reset");
    usb_cause_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && ev == 8'h80 |=> s_reg.cause == 8'h80)
        else $error("usb cause not recorded");
    cmp_source_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && s_reg.enable[5] && !cmp0_out
            |=> sys_reset && s_reg.cause[5] == (($past(ev) & 8'h4F) == 8'h00))
        else $error("comparator reset misbehaved");
    wdt_cause_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && ev == 8'h08 |=> s_reg.cause == 8'h08)
        else $error("watchdog cause not recorded");
    lclk_cause_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && ev == 8'h04 |=> s_reg.cause == 8'h04)
        else $error("lost clock cause not recorded");
    supply_cause_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && s_reg.enable[1] && !supply_ok
            |=> s_reg.cause == 8'h02 ##1 sys_reset)
        else $error("supply reset not recorded");
    cause_stable_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && ev == 8'h00 |=> $stable(s_reg.cause))
        else $error("cause flags changed without a reset");
    enable_write_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && ev == 8'h00 && wr_hit
            |=> s_reg.enable == ($past(sfr_req.wdata) & 8'hA6))
        else $error("enable write not stored");
    read_back_a : assert property (
        @(posedge clk) disable iff (reset) rd_hit |=> sfr_rdata == $past(s_reg.cause))
        else $error("read did not return cause flags");
    hold_release_a : assert property (
        @(posedge clk) disable iff (reset) $fell(sys_reset) |-> $past(rst_pin_n) && $past(s_reg.hold) == 8'h01)
        else $error("system reset released early");

    // refusal, hold and remaining cause, source and enable checks
    write_blocked_a : assert property (
        @(posedge clk) disable iff (reset) s_reg.sys_reset && wr_hit |=> s_reg.enable == $past(s_reg.enable))
        else $error("enable write taken during system reset");
    flash_cause_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && ev == 8'h40 |=> sys_reset && s_reg.cause == 8'h40)
        else $error("flash fault cause not recorded");
    reset_enables_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && ev != 8'h00 |=> s_reg.enable == 8'h02)
        else $error("enables not restored by system reset");
    pin_hold_a : assert property (
        @(posedge clk) disable iff (reset) s_reg.sys_reset && !rst_pin_n
            |=> sys_reset && s_reg.hold == HOLD_CYCLES[rsf_pkg::HOLD_W-1:0])
        else $error("pin low did not extend the system reset");
    supply_hold_a : assert property (
        @(posedge clk) disable iff (reset) s_reg.sys_reset && s_reg.enable[1] && !supply_ok |=> sys_reset)
        else $error("supply low did not extend the system reset");
    other_addr_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && ev == 8'h00 && !wr_hit |=> $stable(s_reg.enable))
        else $error("enables changed without a write at the register address");
    rdata_hold_a : assert property (
        @(posedge clk) disable iff (reset) !rd_hit |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
    usb_bus_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && s_reg.enable[7] && usb_bus_reset |=> sys_reset)
        else $error("usb bus reset with usb enabled gave no reset");
    lclk_off_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.enable[2] |=> !lost_timeout)
        else $error("lost clock timeout while detector disabled");
    enable_ro_bits_a : assert property (
        @(posedge clk) disable iff (reset) (s_reg.enable & 8'h59) == 8'h00)
        else $error("read-only bit stored as an enable");
    quiet_run_a : assert property (
        @(posedge clk) disable iff (reset) !s_reg.sys_reset && ev == 8'h00 |=> !sys_reset)
        else $error("system reset without a cause");
    hold_count_a : assert property (
        @(posedge clk) disable iff (reset) s_reg.sys_reset && s_reg.hold > 8'h01 |=> sys_reset)
        else $error("system reset released before the hold ran out");
endmodule

// *** tb_top.sv ***
// self-checking bench for the reset cause and source enable block
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    logic                  clk;
    logic                  reset;
    rsf_pkg::rsf_sfr_req_t sfr_req;
    logic                  usb_bus_reset;
    logic                  vbus_level;
    logic                  cmp0_out;
    logic                  wdt_overflow;
    logic                  flash_fault;
    logic                  supply_ok;
    logic                  rst_pin_n;
    logic                  sysclk_level;
    logic [7:0]            sfr_rdata;
    logic                  sys_reset;
    logic                  sys_run;
    logic [7:0]            rd;
    int                    n;
    int                    err_total;
    int                    compares;

    rsf_reset_source_flags #(.HOLD_CYCLES(8), .LCLK_TIMEOUT_CYCLES(4)) i_rsf_reset_source_flags (
        .clk(clk), .reset(reset), .sfr_req(sfr_req), .usb_bus_reset(usb_bus_reset),
        .vbus_level(vbus_level), .cmp0_out(cmp0_out), .wdt_overflow(wdt_overflow),
        .flash_fault(flash_fault), .supply_ok(supply_ok), .rst_pin_n(rst_pin_n),
        .sysclk_level(sysclk_level), .sfr_rdata(sfr_rdata), .sys_reset(sys_reset)
    );

    initial clk = 1'b0;
    always #20 clk = ~clk;
    // watched clock toggles so the detector stays quiet until a case freezes it
    always @(negedge clk) begin
        if (reset) begin
            sysclk_level <= 1'b0;
        end else if (sys_run) begin
            sysclk_level <= ~sysclk_level;
        end
    end

    task automatic conclude();
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // full byte writes only, reads show causes not enables
    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        sfr_req.addr  = addr;
        sfr_req.wdata = data;
        sfr_req.wr    = 1'b1;
        @(negedge clk);
        sfr_req.wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
        sfr_req.addr = addr;
        sfr_req.rd   = 1'b1;
        @(negedge clk);
        sfr_req.rd = 1'b0;
        data       = sfr_rdata;
        @(negedge clk);
    endtask

    task automatic wait_level(input logic lvl);
        int k;
        k = 0;
        while (sys_reset !== lvl) begin
            @(negedge clk);
            k++;
            if (k > 200) begin
                err_total++;
                conclude();
            end
        end
    endtask

    task automatic quiet_check(input int cycles);
        repeat (cycles) begin
            @(negedge clk);
            `CHK(sys_reset, 1'b0)
        end
    endtask

    // enable a source, provoke it, then read back the one-hot cause
    task automatic fire(input int kind, input logic [7:0] en, input logic [7:0] exp_cause);
        logic [7:0] got;
        sfr_write(rsf_pkg::RSF_ADDR, en);
        case (kind)
            0: usb_bus_reset = 1'b1;
            1: vbus_level = ~vbus_level;
            2: cmp0_out = 1'b0;
            3: wdt_overflow = 1'b1;
            4: flash_fault = 1'b1;
            5: sys_run = 1'b0;
            6: rst_pin_n = 1'b0;
            default: supply_ok = 1'b0;
        endcase
        wait_level(1'b1);
        usb_bus_reset = 1'b0;
        cmp0_out      = 1'b1;
        wdt_overflow  = 1'b0;
        flash_fault   = 1'b0;
        sys_run       = 1'b1;
        rst_pin_n     = 1'b1;
        supply_ok     = 1'b1;
        wait_level(1'b0);
        sfr_read(rsf_pkg::RSF_ADDR, got);
        `CHK(got, exp_cause)
    endtask

    initial begin
        err_total = 0;
        compares = 0;
        reset = 1'b1;
        sfr_req = '0;
        usb_bus_reset = 1'b0;
        vbus_level = 1'b0;
        cmp0_out = 1'b1;
        wdt_overflow = 1'b0;
        flash_fault = 1'b0;
        supply_ok = 1'b1;
        rst_pin_n = 1'b1;
        sys_run = 1'b1;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        wait_level(1'b0);
        `CHK(sfr_rdata, 8'h00)
        sfr_read(rsf_pkg::RSF_ADDR, rd);
        `CHK(rd, 8'h02)
        sfr_write(8'hEE, 8'h10);
        quiet_check(3);
        sfr_write(rsf_pkg::RSF_ADDR, 8'h49);
        quiet_check(5);
        // forced reset: hold length counted from the write edge
        sfr_req.addr  = rsf_pkg::RSF_ADDR;
        sfr_req.wdata = 8'h10;
        sfr_req.wr    = 1'b1;
        @(negedge clk);
        sfr_req.wr = 1'b0;
        n = 0;
        while (sys_reset === 1'b1 && n < 20) begin
            n++;
            @(negedge clk);
        end
        `CHK(n, 32'h8)
        // cause is now new, so a decoded stray read would show it
        sfr_read(8'hEE, rd);
        `CHK(sfr_rdata, 8'h02)
        sfr_read(rsf_pkg::RSF_ADDR, rd);
        `CHK(rd, 8'h10)
        fire(0, 8'h80, 8'h80);
        fire(1, 8'h80, 8'h80);
        fire(2, 8'h20, 8'h20);
        fire(3, 8'h00, 8'h08);
        fire(4, 8'h00, 8'h40);
        fire(5, 8'h04, 8'h04);
        fire(6, 8'h00, 8'h01);
        fire(7, 8'h02, 8'h02);
        // enables cleared: disabled sources must stay silent
        sfr_write(rsf_pkg::RSF_ADDR, 8'h00);
        cmp0_out = 1'b0;
        usb_bus_reset = 1'b1;
        supply_ok = 1'b0;
        sys_run = 1'b0;
        quiet_check(12);
        cmp0_out = 1'b1;
        usb_bus_reset = 1'b0;
        supply_ok = 1'b1;
        sys_run = 1'b1;
        conclude();
    end
endmodule
